//--- src/uet_engine.sv
// Behaviour
// R1: errored OUT rewinds write pointer, no flag
// R2: errored IN rewinds read pointer, resends
// R3: retries accepted without any limit
// R4: high-speed PING ACKed when full packet fits
// R5: PING NAKed while full packet cannot fit
// R6: OUT ACK if a full packet still fits, else NYET (high-speed only)
// R7: IN sends max packet or validated short
// R8: interrupt/iso max packet multiple of eight (not checked: ep_mps takes any value written to ADDR_EP_CFG)
// R9: max packet size within per-type limits (not checked: any 11-bit ep_mps is accepted for every ep_type)
// R10: non-control endpoints carry one direction only
// R11: setup bytes held in CPU-readable bank
// R12: setup detection sets status, interrupts CPU
// R13: auto-enumerate bit lets device answer standard
// R14: setup ACKed only when eight bytes intact
// R15: setup flag set once eight bytes stored
// R16: setup reception sets status-stage hold bit
// R17: data OUT token flag, bytes into FIFO
// R18: FIFO full on extra byte gives NAK
// R19: NAKed or timed-out packet flushed, no flag
// R20: halted endpoint stores nothing, answers STALL
// R21: CPU halts on excess control write data
// R22: status IN: flag, NAK until ready, ZLP
// R23: transfer is setup, data, then status
`timescale 1ns/1ns
`default_nettype none
module uet_engine #(
  parameter int FIFO_AW = 6
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // token from packet layer
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_kind,
  input  wire logic        hs_mode,
  // received data packet
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  input  wire logic        rx_ok,
  // transmitted data packet
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  output logic             tx_zlp,
  // host answer to our data
  input  wire logic        host_ack,
  input  wire logic        host_timeout,
  // handshake to packet layer
  output logic             hs_valid,
  output logic      [2:0]  hs_code,
  // cpu notification
  output logic             cpu_irq
);
  import uet_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // fifo must hold at least a 64 byte control packet
  if (FIFO_AW < 6 || FIFO_AW > 11) begin : g_bad_aw
    $error("FIFO_AW out of range 6..11");
  end

  localparam logic [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  uet_state_t         state;
  logic [7:0]         mem [0:(1<<FIFO_AW)-1];
  logic [FIFO_AW:0]   wp, wp_base, rp, rp_base;
  logic [63:0]        setup_sh, setup_q;
  logic [3:0]         rx_cnt;
  logic               rx_setup, rx_drop, rx_ovf;
  logic [11:0]        tx_left;
  logic               tx_short, stat_zlp, ctl_wr_stage;
  logic               auto_enum;
  logic [10:0]        ep_mps;
  logic [1:0]         ep_type;
  logic               ep_dir_in;
  logic               halt, hold, validate;
  logic [7:0]         ep_status;

  // ----------------------------------------------------------------
  // derived terms
  // ----------------------------------------------------------------
  logic        is_ctl, dir_out_ok, dir_in_ok, full, out_pending;
  logic [11:0] mps12, room12, avail12, used_now12;
  logic        tok_take, rx_fin, ev_setup_ok, ev_out_ok, ev_out_bad;
  logic        ev_tx_done, ev_tx_fail, wr_byte, ovf_hit, tx_pop;
  logic        cpu_pop, cpu_push, auto_std, tx_end;

  assign is_ctl      = (ep_type == EPT_CTL);
  assign dir_out_ok  = is_ctl || !ep_dir_in;                   // R10
  assign dir_in_ok   = is_ctl || ep_dir_in;                    // R10
  assign mps12       = {1'b0, ep_mps};
  assign used_now12  = 12'(wp - rp_base);
  assign room12      = 12'(DEPTH) - used_now12;
  assign avail12     = 12'(wp_base - rp_base);
  assign full        = (wp - rp_base) == DEPTH;
  assign out_pending = (wp != rp_base);
  assign tok_take    = tok_valid && (state == S_IDLE || state == S_WAIT);
  assign rx_fin      = (state == S_RX) && rx_end;
  assign ev_setup_ok = rx_fin && rx_setup && rx_ok
                       && (rx_cnt == SETUP_BYTES);             // R14
  assign ev_out_ok   = rx_fin && !rx_setup && !rx_drop && rx_ok && !rx_ovf;
  assign ev_out_bad  = rx_fin && !rx_setup && !rx_drop
                       && (!rx_ok || rx_ovf);
  assign ev_tx_done  = (state == S_WAIT) && host_ack;
  assign ev_tx_fail  = (state == S_WAIT) && (host_timeout || tok_valid);
  assign wr_byte     = (state == S_RX) && rx_valid && !rx_setup
                       && !rx_drop && !rx_ovf && !full;        // R17 R20
  assign ovf_hit     = (state == S_RX) && rx_valid && !rx_setup
                       && !rx_drop && full;                    // R18
  assign tx_pop      = (state == S_TX) && (tx_left != 12'h000)
                       && (tx_ready || !tx_valid);
  assign tx_end      = (state == S_TX) && (tx_left == 12'h000)
                       && (tx_ready || !tx_valid);
  assign cpu_pop     = reg_rd && reg_addr == ADDR_FIFO_DATA
                       && (wp_base != rp_base)
                       && (state == S_IDLE || state == S_RX);
  assign cpu_push    = reg_wr && reg_addr == ADDR_FIFO_DATA && !full
                       && state != S_RX;
  assign auto_std    = auto_enum && (setup_sh[6:5] == 2'h0);   // R13

  // ----------------------------------------------------------------
  // token decision
  // ----------------------------------------------------------------
  uet_state_t tk_next;
  logic       tk_hs_v, tk_zlp, tk_stat;
  logic [2:0] tk_hs;
  logic [11:0] tk_len;

  always_comb begin
    tk_next = S_IDLE;
    tk_hs_v = 1'b0;
    tk_hs   = HS_NAK;
    tk_zlp  = 1'b0;
    tk_stat = 1'b0;
    tk_len  = 12'h000;
    case (tok_kind)
      TOK_SETUP: begin
        if (is_ctl) tk_next = S_RX;                            // R23
      end
      TOK_OUT: begin
        if (dir_out_ok) tk_next = S_RX;                        // R10
      end
      TOK_PING: begin
        if (hs_mode && dir_out_ok && (is_ctl || ep_type == EPT_BULK)) begin
          tk_hs_v = 1'b1;
          if (halt) tk_hs = HS_STALL;
          else if (room12 >= mps12) tk_hs = HS_ACK;            // R4
          else tk_hs = HS_NAK;                                 // R5
        end
      end
      default: begin
        if (dir_in_ok) begin
          if (is_ctl && ctl_wr_stage) begin
            tk_stat = 1'b1;                                    // R22
            if (halt) begin
              tk_hs_v = 1'b1;
              tk_hs   = HS_STALL;
            end else if (hold || out_pending) begin
              tk_hs_v = 1'b1;                                  // R22
            end else begin
              tk_zlp  = 1'b1;
              tk_next = S_WAIT;
            end
          end else if (halt) begin
            tk_hs_v = 1'b1;
            tk_hs   = HS_STALL;
          end else if (avail12 >= mps12) begin
            tk_len  = mps12;                                   // R7
            tk_next = S_TX;
          end else if (validate && avail12 != 12'h000) begin
            tk_len  = avail12;                                 // R7
            tk_next = S_TX;
          end else if (validate) begin
            tk_zlp  = 1'b1;
            tk_next = S_WAIT;
          end else begin
            tk_hs_v = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // transaction sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
    end else if (tok_take) begin
      state <= tk_next;                                        // R23
    end else if (ev_tx_done || host_timeout && state == S_WAIT) begin
      state <= S_IDLE;
    end else if (rx_fin) begin
      state <= S_IDLE;
    end else if (tx_end) begin
      state <= S_WAIT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_setup <= 1'b0;
      rx_drop  <= 1'b0;
      rx_ovf   <= 1'b0;
      rx_cnt   <= 4'h0;
      setup_sh <= 64'h0;
    end else if (tok_take) begin
      rx_setup <= (tok_kind == TOK_SETUP);
      rx_drop  <= (tok_kind == TOK_OUT) && halt;               // R20
      rx_ovf   <= 1'b0;
      rx_cnt   <= 4'h0;
    end else if (state == S_RX && rx_valid) begin
      if (ovf_hit) rx_ovf <= 1'b1;                             // R18
      if (rx_setup && rx_cnt != 4'hf) begin
        setup_sh <= {rx_data, setup_sh[63:8]};                 // R11
        rx_cnt   <= rx_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_byte) mem[wp[FIFO_AW-1:0]] <= rx_data;              // R17
    else if (cpu_push) mem[wp[FIFO_AW-1:0]] <= reg_wdata[7:0];
  end

  // rewinding to the committed base needs no retry count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp      <= '0;
      wp_base <= '0;
    end else begin
      if (ev_out_bad) wp <= wp_base;                           // R1 R3 R19
      else if (wr_byte || cpu_push) wp <= wp + 1'b1;
      if (ev_out_ok) wp_base <= wp;                            // R1
      else if (cpu_push) wp_base <= wp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp      <= '0;
      rp_base <= '0;
    end else begin
      if (tok_take && tok_kind == TOK_IN) rp <= rp_base;       // R2 R3
      else if (ev_tx_fail) rp <= rp_base;                      // R2
      else if (tx_pop || cpu_pop) rp <= rp + 1'b1;
      if (ev_tx_done) rp_base <= rp;                           // R2
      else if (cpu_pop) rp_base <= rp_base + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_zlp   <= 1'b0;
      tx_left  <= 12'h000;
      tx_short <= 1'b0;
      stat_zlp <= 1'b0;
    end else begin
      tx_zlp <= tok_take && tk_zlp;
      if (tok_take && (tk_next == S_TX || tk_zlp)) begin
        tx_left  <= tk_len;
        tx_short <= (tk_len < mps12) && !tk_stat;
        stat_zlp <= tk_stat;
      end else if (tx_pop) begin
        tx_left <= tx_left - 12'h001;
      end
      if (tx_pop) begin
        tx_valid <= 1'b1;
        tx_data  <= mem[rp[FIFO_AW-1:0]];
        tx_last  <= (tx_left == 12'h001);
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_valid <= 1'b0;
      hs_code  <= HS_ACK;
    end else begin
      hs_valid <= 1'b0;
      if (tok_take && tk_hs_v) begin
        hs_valid <= 1'b1;                                      // R4 R5 R22
        hs_code  <= tk_hs;
      end else if (ev_setup_ok) begin
        hs_valid <= 1'b1;                                      // R14
        hs_code  <= HS_ACK;
      end else if (rx_fin && !rx_setup && rx_drop) begin
        hs_valid <= 1'b1;                                      // R20
        hs_code  <= HS_STALL;
      end else if (ev_out_bad && rx_ok) begin
        hs_valid <= 1'b1;                                      // R18
        hs_code  <= HS_NAK;
      end else if (ev_out_ok) begin
        hs_valid <= 1'b1;                                      // R6
        hs_code  <= (hs_mode && room12 < mps12) ? HS_NYET : HS_ACK;
      end
    end
  end

  // ----------------------------------------------------------------
  // setup bank and control state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_q      <= 64'h0;
      ctl_wr_stage <= 1'b0;
    end else if (ev_setup_ok) begin
      setup_q      <= setup_sh;                                // R11
      ctl_wr_stage <= !setup_sh[7];
    end else if (ev_tx_done && stat_zlp) begin
      ctl_wr_stage <= 1'b0;                                    // R23
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt     <= 1'b0;
      hold     <= 1'b0;
      validate <= 1'b0;
    end else begin
      if (ev_setup_ok) halt <= 1'b0;
      else if (reg_wr && reg_addr == ADDR_EP_CTRL) halt <= reg_wdata[CT_HALT];
      // hardware set of hold beats a cpu clear in the same cycle
      if (ev_setup_ok && !auto_std) hold <= 1'b1;              // R16
      else if (ev_setup_ok) hold <= 1'b0;                      // R13
      else if (reg_wr && reg_addr == ADDR_EP_CTRL) hold <= reg_wdata[CT_HOLD];
      if (reg_wr && reg_addr == ADDR_EP_CTRL && reg_wdata[CT_VALIDATE])
        validate <= 1'b1;
      else if (ev_tx_done && tx_short) validate <= 1'b0;
      else if (reg_wr && reg_addr == ADDR_EP_CTRL) validate <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_enum <= 1'b0;
      ep_mps    <= RST_MPS;
      ep_type   <= RST_EP_TYPE;
      ep_dir_in <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_STD_REPLY) begin
      auto_enum <= reg_wdata[STD_AUTO_ENUM];
    end else if (reg_wr && reg_addr == ADDR_EP_CFG) begin
      ep_mps    <= reg_wdata[CFG_MPS_LSB +: 11];
      ep_type   <= reg_wdata[CFG_TYPE_LSB +: 2];
      ep_dir_in <= reg_wdata[CFG_DIR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // status, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [7:0] set_vec, clr_vec;

  always_comb begin
    set_vec = 8'h00;
    set_vec[ST_OUT_TOKEN]  = tok_take && tok_kind == TOK_OUT
                             && dir_out_ok;                    // R17
    set_vec[ST_IN_TOKEN]   = tok_take && tok_kind == TOK_IN && dir_in_ok;
    set_vec[ST_PKT_TX]     = ev_tx_done;                       // R2
    set_vec[ST_PKT_RX]     = ev_out_ok;                        // R1 R19
    set_vec[ST_SETUP]      = ev_setup_ok && !auto_std;         // R12 R15
    set_vec[ST_CTL_STATUS] = tok_take && tk_stat;              // R22
    set_vec[ST_TIMEOUT]    = (ev_out_bad && !rx_ok) || ev_tx_fail;
    set_vec[ST_NAK_SENT]   = hs_valid && hs_code == HS_NAK;
    clr_vec = (reg_wr && reg_addr == ADDR_EP_STATUS) ? reg_wdata[7:0]
                                                     : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ep_status <= 8'h00;
    else ep_status <= (ep_status & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cpu_irq <= 1'b0;
    else cpu_irq <= ep_status[ST_SETUP] || ep_status[ST_PKT_RX]
                    || ep_status[ST_PKT_TX]
                    || ep_status[ST_CTL_STATUS];               // R12
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_STD_REPLY) reg_rdata <= {31'h0, auto_enum};
      else if (reg_addr == ADDR_SETUP_LO) reg_rdata <= setup_q[31:0];
      else if (reg_addr == ADDR_SETUP_HI) reg_rdata <= setup_q[63:32];
      else if (reg_addr == ADDR_EP_CFG)
        reg_rdata <= {13'h0, ep_dir_in, ep_type, 5'h0, ep_mps};
      else if (reg_addr == ADDR_EP_CTRL)
        reg_rdata <= {29'h0, validate, hold, halt};
      else if (reg_addr == ADDR_EP_STATUS) reg_rdata <= {24'h0, ep_status};
      else if (reg_addr == ADDR_FIFO_AVAIL) reg_rdata <= {20'h0, avail12};
      else if (reg_addr == ADDR_FIFO_DATA)
        reg_rdata <= {24'h0, mem[rp[FIFO_AW-1:0]]};
      else reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SETUP_ACK: assert property (ev_setup_ok // R14
    |=> hs_valid && hs_code == HS_ACK)
    else $error("setup not acked");
  AST_SETUP_SILENT: assert property (rx_fin && rx_setup // R14
    && !ev_setup_ok |=> !hs_valid)
    else $error("bad setup answered");
  AST_SETUP_FLAG: assert property (ev_setup_ok && !auto_std // R15
    |=> ep_status[ST_SETUP] && hold && setup_q == $past(setup_sh))
    else $error("setup flag or hold missing");
  AST_IRQ_SETUP: assert property (ep_status[ST_SETUP] |=> cpu_irq) // R12
    else $error("setup irq missing");
  AST_OUT_REWIND: assert property (ev_out_bad // R1
    |=> wp == $past(wp_base)
    && (ep_status[ST_PKT_RX] == $past(ep_status[ST_PKT_RX])))
    else $error("errored out not rewound");
  AST_IN_REWIND: assert property (ev_tx_fail |=> rp == $past(rp_base)) // R2
    else $error("errored in not rewound");
  AST_PING_NAK: assert property (tok_take && tok_kind == TOK_PING // R5
    && hs_mode && is_ctl && !halt && room12 < mps12
    |=> hs_valid && hs_code == HS_NAK)
    else $error("ping not naked");
  AST_HALT_NO_STORE: assert property (state == S_RX && rx_drop // R20
    |-> !wr_byte)
    else $error("halted endpoint stored data");
  AST_HALT_STALL: assert property (rx_fin && rx_drop // R20
    |=> hs_valid && hs_code == HS_STALL)
    else $error("halted endpoint not stalled");
  AST_STATUS_NAK: assert property (tok_take && tk_stat && !halt // R22
    && hold |=> hs_valid && hs_code == HS_NAK && ep_status[ST_CTL_STATUS])
    else $error("status stage not naked");
  AST_TX_LEN: assert property (tok_take && tk_next == S_TX // R7
    |=> (tx_left <= mps12) ##1 tx_valid)
    else $error("in packet too long");

  COV_SETUP: cover property (ev_setup_ok ##1 hs_valid);
  COV_NYET: cover property (hs_valid && hs_code == HS_NYET);
  COV_IN_DONE: cover property (tx_last && tx_ready ##[1:8] ev_tx_done);
  COV_STATUS_ZLP: cover property (tx_zlp && stat_zlp);
endmodule : uet_engine
`default_nettype wire

//--- src/uet_pkg.sv
package uet_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STD_REPLY  = 12'h080;
  localparam logic [11:0] ADDR_SETUP_LO   = 12'h100;
  localparam logic [11:0] ADDR_SETUP_HI   = 12'h104;
  localparam logic [11:0] ADDR_EP_CFG     = 12'h300;
  localparam logic [11:0] ADDR_EP_CTRL    = 12'h304;
  localparam logic [11:0] ADDR_EP_STATUS  = 12'h30c;
  localparam logic [11:0] ADDR_FIFO_AVAIL = 12'h310;
  localparam logic [11:0] ADDR_FIFO_DATA  = 12'h318;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STD_AUTO_ENUM  = 0;
  localparam int ST_OUT_TOKEN   = 0;
  localparam int ST_IN_TOKEN    = 1;
  localparam int ST_PKT_TX      = 2;
  localparam int ST_PKT_RX      = 3;
  localparam int ST_SETUP       = 4;
  localparam int ST_CTL_STATUS  = 5;
  localparam int ST_TIMEOUT     = 6;
  localparam int ST_NAK_SENT    = 7;
  localparam int CT_HALT        = 0;
  localparam int CT_HOLD        = 1;
  localparam int CT_VALIDATE    = 2;
  localparam int CFG_MPS_LSB    = 0;
  localparam int CFG_TYPE_LSB   = 16;
  localparam int CFG_DIR_BIT    = 18;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [10:0] RST_MPS       = 11'h040;
  localparam logic [1:0]  RST_EP_TYPE   = 2'h0;
  localparam logic [3:0]  SETUP_BYTES   = 4'h8;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TOK_OUT   = 2'h0;
  localparam logic [1:0] TOK_IN    = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  localparam logic [1:0] TOK_PING  = 2'h3;
  localparam logic [2:0] HS_ACK    = 3'h0;
  localparam logic [2:0] HS_NAK    = 3'h1;
  localparam logic [2:0] HS_NYET   = 3'h2;
  localparam logic [2:0] HS_STALL  = 3'h3;
  localparam logic [1:0] EPT_CTL   = 2'h0;
  localparam logic [1:0] EPT_ISO   = 2'h1;
  localparam logic [1:0] EPT_BULK  = 2'h2;
  localparam logic [1:0] EPT_INT   = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RX   = 4'h2,
    S_TX   = 4'h4,
    S_WAIT = 4'h8
  } uet_state_t;
endpackage : uet_pkg

//--- test/uet_host.sv
`timescale 1ns/1ns
`default_nettype none
module uet_host (
  // link side
  input  wire logic       clk,
  input  wire logic       hs_valid,
  input  wire logic [2:0] hs_code,
  output logic            tok_valid,
  output logic      [1:0] tok_kind,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  output logic            rx_ok,
  output logic            host_ack,
  output logic            host_timeout
);
  // 7 means no handshake seen
  logic [2:0] got = 3'h7;
  // first data byte of every packet, bytes count up from it
  logic [7:0] base = 8'h20;
  initial begin
    {tok_valid, tok_kind, rx_valid, rx_end, rx_ok} = '0;
    {host_ack, host_timeout, rx_data} = '0;
  end
  always @(posedge clk) if (hs_valid) got <= hs_code;
  // token, data, end of packet, then wait for the answer
  task automatic xact(input logic [1:0] k, input int n, input logic ok);
    @(posedge clk);
    got <= 3'h7;
    tok_kind <= k;
    tok_valid <= 1'b1;
    @(posedge clk);
    tok_valid <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= base + 8'(i);
      @(posedge clk);
    end
    // released data line must not hold the last byte
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    if (n >= 0) begin
      rx_end <= 1'b1;
      rx_ok <= ok;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_ok <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask : xact
  // t high: host lost our data packet and times out instead
  task automatic ack(input logic t);
    host_ack <= !t;
    host_timeout <= t;
    @(posedge clk);
    host_ack <= 1'b0;
    host_timeout <= 1'b0;
  endtask : ack
endmodule : uet_host
`default_nettype wire

//--- test/usb2_endpoint_transaction_engine_bench.sv
`timescale 1ns/1ns
`default_nettype none
module usb2_endpoint_transaction_engine_bench;
  import uet_pkg::*;
  logic        clk = 0, rst, reg_wr, reg_rd, hs_mode, tx_ready;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        tok_valid, rx_valid, rx_end, rx_ok, host_ack, host_timeout;
  logic [1:0]  tok_kind;
  logic [7:0]  rx_data, tx_data;
  logic        tx_valid, tx_last, tx_zlp, hs_valid, cpu_irq;
  logic [2:0]  hs_code;
  logic        zlp_seen = 0;
  int          n_errors = 0, check_count = 0, cycles = 0;
  always #20 clk = ~clk;
  uet_engine #(.FIFO_AW(6)) dut_u (.*);
  uet_host host_u (.clk(clk), .hs_valid(hs_valid), .hs_code(hs_code),
    .tok_valid(tok_valid), .tok_kind(tok_kind), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_ok(rx_ok),
    .host_ack(host_ack), .host_timeout(host_timeout));
  always @(posedge clk) if (tx_zlp) zlp_seen <= 1'b1;
  // last two accepted bytes with their last flags
  logic [17:0] tx_log = '0;
  int          n_tx = 0;
  always @(posedge clk) if (tx_valid && tx_ready) begin
    tx_log <= {tx_log[8:0], tx_last, tx_data};
    n_tx <= n_tx + 1;
  end
  // ----------
  // tasks
  // ----------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // generous ceiling, run needs a few hundred cycles
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rc
  task automatic rb(input logic [11:0] a, input int b, input logic e);
    rd(a);
    chk({31'h0, rv[b]}, {31'h0, e});
  endtask : rb
  task automatic hc(input logic [1:0] k, input int n, input logic ok,
                    input logic [2:0] e);
    host_u.xact(k, n, ok);
    chk({29'h0, host_u.got}, {29'h0, e});
  endtask : hc
  initial begin
    {reg_wr, reg_rd, hs_mode, reg_addr, reg_wdata} = '0;
    tx_ready = 1'b1;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(ADDR_STD_REPLY, 32'h0);
    rc(12'h200, 32'h0);
    hc(TOK_SETUP, 7, 1'b1, 3'h7);
    hc(TOK_SETUP, 8, 1'b0, 3'h7);
    hc(TOK_SETUP, 8, 1'b1, HS_ACK);
    rb(ADDR_EP_STATUS, ST_SETUP, 1'b1);
    chk({31'h0, cpu_irq}, 32'h1);
    rc(ADDR_SETUP_LO, 32'h23222120);
    rc(ADDR_SETUP_HI, 32'h27262524);
    rb(ADDR_EP_CTRL, CT_HOLD, 1'b1);
    $display("test setup done");
    wr(ADDR_EP_STATUS, 32'hff);
    hc(TOK_OUT, 2, 1'b0, 3'h7);
    rb(ADDR_EP_STATUS, ST_PKT_RX, 1'b0);
    rc(ADDR_FIFO_AVAIL, 32'h0);
    hc(TOK_OUT, 2, 1'b0, 3'h7);
    hc(TOK_OUT, 2, 1'b1, HS_ACK);
    rb(ADDR_EP_STATUS, ST_PKT_RX, 1'b1);
    rb(ADDR_EP_STATUS, ST_OUT_TOKEN, 1'b1);
    rc(ADDR_FIFO_AVAIL, 32'h2);
    $display("test out done");
    hc(TOK_IN, -1, 1'b1, HS_NAK);
    rb(ADDR_EP_STATUS, ST_CTL_STATUS, 1'b1);
    wr(ADDR_EP_CTRL, 32'h0);
    hc(TOK_IN, -1, 1'b1, HS_NAK);
    rc(ADDR_FIFO_DATA, 32'h20);
    rc(ADDR_FIFO_DATA, 32'h21);
    hc(TOK_IN, -1, 1'b1, 3'h7);
    chk({31'h0, zlp_seen}, 32'h1);
    host_u.ack(1'b0);
    $display("test status done");
    hs_mode <= 1'b1;
    hc(TOK_PING, -1, 1'b1, HS_ACK);
    hc(TOK_OUT, 2, 1'b1, HS_NYET);
    hc(TOK_PING, -1, 1'b1, HS_NAK);
    wr(ADDR_EP_CTRL, 32'h1);
    hc(TOK_OUT, 2, 1'b1, HS_STALL);
    rc(ADDR_FIFO_AVAIL, 32'h2);
    $display("test flow done");
    wr(ADDR_EP_CFG, 32'h0007_0008);
    hc(TOK_OUT, 2, 1'b1, 3'h7);
    wr(ADDR_EP_STATUS, 32'hff);
    wr(ADDR_EP_CTRL, 32'h4);
    hc(TOK_IN, -1, 1'b1, 3'h7);
    host_u.ack(1'b1);
    rb(ADDR_EP_STATUS, ST_PKT_TX, 1'b0);
    hc(TOK_IN, -1, 1'b1, 3'h7);
    chk({14'h0, tx_log}, 32'h4121);
    chk(n_tx, 4);
    host_u.ack(1'b0);
    rb(ADDR_EP_STATUS, ST_PKT_TX, 1'b1);
    rc(ADDR_FIFO_AVAIL, 32'h0);
    $display("test in done");
    wr(ADDR_EP_CFG, 32'h40);
    wr(ADDR_STD_REPLY, 32'h1);
    host_u.base <= 8'h00;
    hc(TOK_SETUP, 8, 1'b1, HS_ACK);
    rb(ADDR_EP_STATUS, ST_SETUP, 1'b0);
    hc(TOK_IN, -1, 1'b1, 3'h7);
    host_u.ack(1'b0);
    $display("test auto done");
    report_and_stop();
  end
endmodule : usb2_endpoint_transaction_engine_bench
`default_nettype wire
